// *** design/rifs_holdoff.sv ***
// rifs_holdoff: hold-off countdown stepped by prescaled vcxo pulses.
// assumes vcxo_pulse is a one-cycle strobe per vcxo-pll output pulse.
`timescale 1ns/100ps
`default_nettype none
module rifs_holdoff
  import rifs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic vcxo_pulse,
  input wire logic [RIFS_HO_STEP_W-1:0] step,
  input wire logic [7:0] count,
  output logic expired
);

  typedef struct packed {
    logic [RIFS_HO_STEP_W-1:0] pre;
    logic [7:0] cnt;
    logic exp;
  } rifs_ho_st_t;

  rifs_ho_st_t q, d;

  // idle keeps the counter loaded so a new loss starts a full period
  always_comb
  begin
    d = q;
    d.exp = 1'b0;
    if (!run)
    begin
      d.pre = '0;
      d.cnt = count;
    end
    else if (vcxo_pulse)
    begin
      d.pre = q.pre + 1'b1;
      if (q.pre >= step - 1'b1)
      begin
        d.pre = '0; // RULE7
        if (q.cnt <= 8'h01)
        begin
          d.exp = 1'b1; // RULE6
          d.cnt = count; // RULE8
        end
        else
          d.cnt = q.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '{pre: '0, cnt: RIFS_RST_HO_COUNT, exp: 1'b0};
    else
      q <= d;
  end

  assign expired = q.exp;

endmodule
`default_nettype wire

// *** design/rifs_input_mon.sv ***
// rifs_input_mon: activity monitor and re-validation counter of one input.
// assumes edge_seen is a one-cycle strobe per input edge, synchronous.
`timescale 1ns/100ps
`default_nettype none
module rifs_input_mon
  import rifs_pkg::*;
#(
  parameter int TIMEOUT = RIFS_LOS_TIMEOUT_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic edge_seen,
  input wire logic enable,
  input wire logic div4,
  input wire logic [1:0] rv_code,
  output logic los,
  output logic revalidated
);

  typedef struct packed {
    logic [15:0] gap;
    logic [6:0] rv;
    logic [1:0] div;
    logic los;
    logic rv_done;
  } rifs_mon_st_t;

  rifs_mon_st_t q, d;

  // period watch and countdown; a disabled input counts as lost
  always_comb
  begin
    d = q;
    d.rv_done = 1'b0;
    if (!enable)
    begin
      d.gap = '0;
      d.div = '0;
      d.los = 1'b1;
      d.rv = rifs_rv_len(rv_code);
    end
    else if (edge_seen)
    begin
      d.gap = '0;
      if (q.los)
      begin
        // divide by four groups periods for fast inputs (RULE21)
        d.div = q.div + 2'h1;
        if (!div4 || q.div == RIFS_RV_DIV4_LAST)
        begin
          d.div = '0;
          d.rv = q.rv - 7'h01; // RULE10
          if (q.rv <= 7'h01)
          begin
            d.los = 1'b0; // RULE12
            d.rv_done = 1'b1;
          end
        end
      end
    end
    else if (q.gap == 16'(TIMEOUT - 1))
    begin
      // an empty period: flag loss, or restart the countdown
      d.gap = '0;
      d.div = '0;
      d.los = 1'b1;
      d.rv = rifs_rv_len(rv_code); // RULE10 RULE11 RULE13 RULE14
    end
    else
      d.gap = q.gap + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '{gap: '0, rv: RIFS_RV_LEN2, div: '0, los: 1'b1, rv_done: 1'b0};
    else
      q <= d;
  end

  assign los = q.los;
  assign revalidated = q.rv_done;

endmodule
`default_nettype wire

// *** design/rifs_pkg.sv ***
// rifs_pkg: constants, register map and carrier types of the reference
// input selector; assumes a single 50 MHz core clock domain.
package rifs_pkg;

  // register byte offsets on the bus
  localparam logic [11:0] RIFS_OFS_CTRL = 12'h000;
  localparam logic [11:0] RIFS_OFS_PRIO = 12'h004;
  localparam logic [11:0] RIFS_OFS_HOLDOFF = 12'h008;
  localparam logic [11:0] RIFS_OFS_REVAL = 12'h00c;
  localparam logic [11:0] RIFS_OFS_STATUS = 12'h010;

  // status register field positions
  localparam int RIFS_ST_LOS0 = 0;
  localparam int RIFS_ST_LOS1 = 1;
  localparam int RIFS_ST_SEL = 2;
  localparam int RIFS_ST_HOLD = 3;
  localparam int RIFS_ST_LIVE = 4;
  localparam int RIFS_ST_STICKY = 5;

  // values after reset
  localparam logic [1:0] RIFS_RST_MODE = 2'h0;
  localparam logic [1:0] RIFS_RST_MANUAL = 2'h0;
  localparam logic [1:0] RIFS_RST_PRIO0 = 2'h3;
  localparam logic [1:0] RIFS_RST_PRIO1 = 2'h2;
  localparam logic [7:0] RIFS_RST_HO_COUNT = 8'h80;
  localparam logic [1:0] RIFS_RST_HO_PRESCALE = 2'h2;
  localparam logic [1:0] RIFS_RST_RV_CODE = 2'h2;

  // re-validation lengths in counted units (one unit is one or four periods)
  localparam logic [6:0] RIFS_RV_LEN0 = 7'h02;
  localparam logic [6:0] RIFS_RV_LEN1 = 7'h10;
  localparam logic [6:0] RIFS_RV_LEN2 = 7'h20;
  localparam logic [6:0] RIFS_RV_LEN3 = 7'h40;
  localparam logic [1:0] RIFS_RV_DIV4_LAST = 2'h3;

  // missing-edge window of an input, in core cycles
  localparam int RIFS_LOS_TIMEOUT_CYC = 64;
  localparam int RIFS_HO_STEP_W = 20;

  typedef enum logic [1:0] {
    RIFS_MODE_MANUAL = 2'b00,
    RIFS_MODE_AUTO = 2'b01,
    RIFS_MODE_SHORT_HOLD = 2'b10,
    RIFS_MODE_AUTO_HOLD = 2'b11
  } rifs_mode_t;

  // software-written configuration
  typedef struct packed {
    rifs_mode_t mode;
    logic [1:0] manual;
    logic revertive;
    logic rv_div4;
    logic mask_ref_loss;
    logic [1:0] powerdown;
    logic [1:0] prio0;
    logic [1:0] prio1;
    logic [7:0] ho_count;
    logic [1:0] ho_prescale;
    logic [1:0] rv_code;
  } rifs_cfg_t;

  // re-validation length from its code
  function automatic logic [6:0] rifs_rv_len(input logic [1:0] code);
    case (code)
      2'h0: rifs_rv_len = RIFS_RV_LEN0;
      2'h1: rifs_rv_len = RIFS_RV_LEN1;
      2'h2: rifs_rv_len = RIFS_RV_LEN2;
      default: rifs_rv_len = RIFS_RV_LEN3;
    endcase
  endfunction

endpackage

// *** design/rifs_top.sv ***
// rifs_top: reference input selection and fail-over for the first-stage pll,
// with an ahb-lite register slave. assumes all inputs synchronous to
// CORE_CLK and edge/pulse inputs one cycle wide.
// Summary of operation
// (RULE1) mode code: manual, auto, short holdover, auto-holdover
// (RULE2) manual modes take reference from manual choice
// (RULE3) auto modes select by loss flags, priorities
// (RULE4) auto modes ignore the manual choice field
// (RULE5) manual choice 00 input0, 01 input1
// (RULE6) auto-holdover: countdown after loss, switch at zero
// (RULE7) step is prescaled vcxo pulses; period count times step
// (RULE8) counter reloads from setting after each zero
// (RULE9) hold-off count resets 0x80, prescale code 10
// (RULE10) loss loads re-validation count; valid periods decrement
// (RULE11) missing period reloads re-validation countdown
// (RULE12) countdown done clears that input's loss flag
// (RULE13) undivided codes need 2, 16, 32, 64 periods
// (RULE14) divided codes need 8, 64, 128, 256 periods
// (RULE15) powerdown bit 1 disables input, 0 enables
// (RULE16) software powers down unused inputs in manual modes
// (RULE17) unlock flags include selected reference loss unless masked
// (RULE18) mask also keeps reference loss off lock pin
// (RULE19) higher priority wins; ties go to input0
// (RULE20) revertive: reselect only to higher-priority re-validated input
// (RULE21) re-validation prescale divides by one or four
// (RULE22) auto without holdover switches immediately on loss
// (RULE23) short holdover keeps manual choice, holds pll control
`timescale 1ns/100ps
`default_nettype none
module rifs_top
  import rifs_pkg::*;
#(
  parameter int HO_STEP_00 = 32768,
  parameter int HO_STEP_01 = 65536,
  parameter int HO_STEP_10 = 131072,
  parameter int HO_STEP_11 = 262144,
  parameter int LOS_TIMEOUT = RIFS_LOS_TIMEOUT_CYC
)
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [1:0] REF_EDGE,
  input wire logic VCXO_PULSE,
  input wire logic PLL_UNLOCK,
  output logic REF_SELECT,
  output logic PLL_HOLDOVER,
  output logic [1:0] INPUT_POWERDOWN,
  output logic [1:0] INPUT_LOS,
  output logic LIVE_PLL1_UNLOCK,
  output logic STICKY_PLL1_UNLOCK,
  output logic LOCK
);

  typedef struct packed {
    rifs_cfg_t cfg;
    logic wr_pend;
    logic [11:0] addr;
    logic [31:0] rdata;
    logic sel;
    logic hold;
    logic live;
    logic sticky;
    logic lock;
  } rifs_top_st_t;

  rifs_top_st_t q, d;
  logic [1:0] los;
  logic [1:0] reval;
  logic ho_run;
  logic ho_expired;
  logic [RIFS_HO_STEP_W-1:0] ho_step;

  // best usable input: higher priority first, input0 on a tie
  function automatic logic best_input(input logic [1:0] l,
    input logic [1:0] p0, input logic [1:0] p1, input logic cur);
    if (!l[0] && !l[1])
      best_input = (p1 > p0); // RULE19
    else if (!l[0])
      best_input = 1'b0;
    else if (!l[1])
      best_input = 1'b1;
    else
      best_input = cur;
  endfunction

  // priority of one input
  function automatic logic [1:0] prio_of(input rifs_cfg_t c,
    input logic i);
    prio_of = i ? c.prio1 : c.prio0;
  endfunction

  // register read decode; unmapped addresses read zero
  function automatic logic [31:0] read_reg(input rifs_top_st_t s,
    input logic [11:0] a, input logic [1:0] l);
    read_reg = '0;
    case (a)
      RIFS_OFS_CTRL:
        read_reg[8:0] = {s.cfg.powerdown[1], s.cfg.powerdown[0],
          s.cfg.mask_ref_loss, s.cfg.rv_div4, s.cfg.revertive,
          s.cfg.manual, s.cfg.mode};
      RIFS_OFS_PRIO:
        read_reg[3:0] = {s.cfg.prio1, s.cfg.prio0};
      RIFS_OFS_HOLDOFF:
        read_reg[9:0] = {s.cfg.ho_prescale, s.cfg.ho_count};
      RIFS_OFS_REVAL:
        read_reg[1:0] = s.cfg.rv_code;
      RIFS_OFS_STATUS:
      begin
        read_reg[RIFS_ST_LOS0] = l[0];
        read_reg[RIFS_ST_LOS1] = l[1];
        read_reg[RIFS_ST_SEL] = s.sel;
        read_reg[RIFS_ST_HOLD] = s.hold;
        read_reg[RIFS_ST_LIVE] = s.live;
        read_reg[RIFS_ST_STICKY] = s.sticky;
      end
      default: read_reg = '0;
    endcase
  endfunction

  // one monitor per reference input
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_mon
      rifs_input_mon #(
        .TIMEOUT(LOS_TIMEOUT)
      ) u_mon (
        .clk(CORE_CLK),
        .rst(RST),
        .edge_seen(REF_EDGE[gi]),
        .enable(!q.cfg.powerdown[gi]), // RULE15
        .div4(q.cfg.rv_div4), // RULE21
        .rv_code(q.cfg.rv_code),
        .los(los[gi]),
        .revalidated(reval[gi])
      );
    end
  endgenerate

  // step length from the prescale code; long counts stay parameters
  always_comb
  begin
    case (q.cfg.ho_prescale)
      2'h0: ho_step = RIFS_HO_STEP_W'(HO_STEP_00);
      2'h1: ho_step = RIFS_HO_STEP_W'(HO_STEP_01);
      2'h2: ho_step = RIFS_HO_STEP_W'(HO_STEP_10); // RULE9
      default: ho_step = RIFS_HO_STEP_W'(HO_STEP_11);
    endcase
  end

  // hold-off only runs while the chosen input is lost in auto-holdover
  assign ho_run = (q.cfg.mode == RIFS_MODE_AUTO_HOLD) && los[q.sel]; // RULE6

  rifs_holdoff u_holdoff (
    .clk(CORE_CLK),
    .rst(RST),
    .run(ho_run),
    .vcxo_pulse(VCXO_PULSE),
    .step(ho_step),
    .count(q.cfg.ho_count),
    .expired(ho_expired)
  );

  // bus slave, selection and lock reporting
  always_comb
  begin
    logic cand;
    logic accept;
    logic cur_lost;
    cand = 1'b0;
    accept = 1'b0;
    cur_lost = 1'b0;
    d = q;

    // zero wait states: read data is fetched during the address phase,
    // so a read must not directly follow a write in its data phase
    accept = HSEL && HTRANS[1] && HREADY;
    d.wr_pend = accept && HWRITE;
    if (accept)
      d.addr = HADDR[11:0];
    if (accept && !HWRITE)
      d.rdata = read_reg(q, HADDR[11:0], los);

    // write data phase
    if (q.wr_pend)
    begin
      case (q.addr)
        RIFS_OFS_CTRL:
        begin
          d.cfg.mode = rifs_mode_t'(HWDATA[1:0]); // RULE1
          d.cfg.manual = HWDATA[3:2];
          d.cfg.revertive = HWDATA[4];
          d.cfg.rv_div4 = HWDATA[5];
          d.cfg.mask_ref_loss = HWDATA[6];
          d.cfg.powerdown = HWDATA[8:7];
        end
        RIFS_OFS_PRIO:
        begin
          d.cfg.prio0 = HWDATA[1:0];
          d.cfg.prio1 = HWDATA[3:2];
        end
        RIFS_OFS_HOLDOFF:
        begin
          d.cfg.ho_count = HWDATA[7:0];
          d.cfg.ho_prescale = HWDATA[9:8];
        end
        RIFS_OFS_REVAL:
          d.cfg.rv_code = HWDATA[1:0];
        default:
          d.cfg = q.cfg;
      endcase
    end

    // reference choice per mode
    cand = best_input(los, q.cfg.prio0, q.cfg.prio1, q.sel); // RULE3
    cur_lost = los[q.sel];
    d.hold = 1'b0;
    case (q.cfg.mode)
      RIFS_MODE_MANUAL:
        d.sel = q.cfg.manual[0]; // RULE2 RULE5
      RIFS_MODE_SHORT_HOLD:
      begin
        d.sel = q.cfg.manual[0]; // RULE2 RULE5
        d.hold = los[q.cfg.manual[0]]; // RULE23
      end
      RIFS_MODE_AUTO:
      begin
        // manual choice is not looked at here (RULE4)
        if (cur_lost)
          d.sel = cand; // RULE22
        else if (q.cfg.revertive && reval[!q.sel] && cand != q.sel &&
          prio_of(q.cfg, cand) > prio_of(q.cfg, q.sel))
          d.sel = cand; // RULE20
      end
      RIFS_MODE_AUTO_HOLD:
      begin
        d.hold = cur_lost;
        if (ho_expired)
          d.sel = cand; // RULE6
        else if (!cur_lost && q.cfg.revertive && reval[!q.sel] &&
          cand != q.sel && prio_of(q.cfg, cand) > prio_of(q.cfg, q.sel))
          d.sel = cand; // RULE20
      end
      default:
        d.sel = q.sel;
    endcase

    // lock reporting, reference loss optionally masked
    d.live = PLL_UNLOCK || (!q.cfg.mask_ref_loss && cur_lost); // RULE17
    d.lock = !(PLL_UNLOCK || (!q.cfg.mask_ref_loss && cur_lost)); // RULE18
    // sticky flag: write one clears, a new unlock in the same cycle wins
    d.sticky = q.sticky;
    if (q.wr_pend && q.addr == RIFS_OFS_STATUS && HWDATA[RIFS_ST_STICKY])
      d.sticky = 1'b0;
    if (d.live)
      d.sticky = 1'b1; // RULE17
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      q <= '0;
      q.cfg.mode <= rifs_mode_t'(RIFS_RST_MODE);
      q.cfg.manual <= RIFS_RST_MANUAL;
      q.cfg.prio0 <= RIFS_RST_PRIO0;
      q.cfg.prio1 <= RIFS_RST_PRIO1;
      q.cfg.ho_count <= RIFS_RST_HO_COUNT; // RULE9
      q.cfg.ho_prescale <= RIFS_RST_HO_PRESCALE; // RULE9
      q.cfg.rv_code <= RIFS_RST_RV_CODE; // RULE13
    end
    else
      q <= d;
  end

  assign HRDATA = q.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign REF_SELECT = q.sel;
  assign PLL_HOLDOVER = q.hold;
  assign INPUT_POWERDOWN = q.cfg.powerdown;
  assign INPUT_LOS = los;
  assign LIVE_PLL1_UNLOCK = q.live;
  assign STICKY_PLL1_UNLOCK = q.sticky;
  assign LOCK = q.lock;

endmodule
`default_nettype wire

// *** verification/rifs_ref_src.sv ***
// rifs_ref_src: two reference sources seen as one-cycle edge strobes.
// assumes the core clock; a stopped source gives no edges at all.
`timescale 1ns/100ps
`default_nettype none
module rifs_ref_src
(
  input wire logic clk,
  input wire logic [1:0] run,
  input wire logic [7:0] period,
  output logic [1:0] edge_o
);
  logic [7:0] cnt_q [2] = '{8'h0, 8'h0};
  initial edge_o = 2'h0;
  // a restarted source begins a fresh phase, so loss windows are exact
  always @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      edge_o[i] <= run[i] && cnt_q[i] == 8'h0;
      if (!run[i] || cnt_q[i] >= period - 8'h1) cnt_q[i] <= 8'h0;
      else cnt_q[i] <= cnt_q[i] + 8'h1;
    end
  end
endmodule
`default_nettype wire

// *** verification/rifs_top_properties.sv ***
// rifs_top_properties: timing relations on the ports of rifs_top.
// assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module rifs_top_properties
#(
  parameter int LOS_TIMEOUT = 64
)
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [1:0] REF_EDGE,
  input wire logic PLL_UNLOCK,
  input wire logic [1:0] INPUT_POWERDOWN,
  input wire logic [1:0] INPUT_LOS,
  input wire logic LIVE_PLL1_UNLOCK,
  input wire logic STICKY_PLL1_UNLOCK,
  input wire logic LOCK
);
  logic [9:0] idle_q;
  logic [9:0] seen_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // quiet time and edges during loss of input 0; saturate, never wrap
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || REF_EDGE[0]) idle_q <= 10'h0;
    else if (idle_q != 10'h3ff) idle_q <= idle_q + 10'h1;
    if (RST || !INPUT_LOS[0]) seen_q <= 10'h0;
    else if (REF_EDGE[0] && seen_q != 10'h3ff) seen_q <= seen_q + 10'h1;
  end
  sequence s_reval0;
    $fell(INPUT_LOS[0]);
  endsequence
  sequence s_unlock;
    $rose(LIVE_PLL1_UNLOCK);
  endsequence
  property p_bus_ok;
    HREADYOUT && !HRESP;
  endproperty
  property p_live;
    PLL_UNLOCK |=> LIVE_PLL1_UNLOCK;
  endproperty
  property p_lock_inv;
    !$past(RST) |-> LOCK != LIVE_PLL1_UNLOCK;
  endproperty
  property p_sticky;
    s_unlock |-> ##[0:1] STICKY_PLL1_UNLOCK;
  endproperty
  property p_pd_los;
    INPUT_POWERDOWN != 2'h0 |->
      ##[0:1] ((INPUT_LOS & INPUT_POWERDOWN) == INPUT_POWERDOWN);
  endproperty
  property p_idle_los;
    int'(idle_q) >= LOS_TIMEOUT + 3 |-> INPUT_LOS[0];
  endproperty
  property p_reval_len;
    s_reval0 |-> seen_q >= 10'h2;
  endproperty
  property p_reval_edge;
    s_reval0 |-> $past(REF_EDGE[0]) || $past(REF_EDGE[0], 2) ||
      $past(REF_EDGE[0], 3);
  endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus slave not ready or not okay");
  a_live: assert property (p_live)
    else $error("unlock did not raise the live flag");
  a_lock_inv: assert property (p_lock_inv)
    else $error("lock pin does not mirror the live flag");
  a_sticky: assert property (p_sticky)
    else $error("sticky flag missed an unlock");
  a_pd_los: assert property (p_pd_los)
    else $error("powered-down input not flagged lost");
  a_idle_los: assert property (p_idle_los)
    else $error("silent input not flagged lost");
  a_reval_len: assert property (p_reval_len)
    else $error("loss cleared after too few edges");
  a_reval_edge: assert property (p_reval_edge)
    else $error("loss cleared without a recent edge");
endmodule
bind rifs_top rifs_top_properties #(.LOS_TIMEOUT(LOS_TIMEOUT)) rifs_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .REF_EDGE(REF_EDGE), .PLL_UNLOCK(PLL_UNLOCK),
  .INPUT_POWERDOWN(INPUT_POWERDOWN), .INPUT_LOS(INPUT_LOS),
  .LIVE_PLL1_UNLOCK(LIVE_PLL1_UNLOCK),
  .STICKY_PLL1_UNLOCK(STICKY_PLL1_UNLOCK), .LOCK(LOCK));
`default_nettype wire

// *** verification/testbench.sv ***
// testbench: drives rifs_top over ahb-lite with two reference sources.
// assumes the design and the source model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import rifs_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic vcxo = 1'b0, unlock = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0, run = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [7:0] period = 8'h3;
  wire [31:0] hrdata;
  wire hready, hresp, ref_sel, hold, live, sticky, lock;
  wire [1:0] ref_edge, pd, los;
  int err_count = 0, samples_checked = 0, cyc = 0, n;
  int m [8] = '{32'h0, 32'hb, 32'h280, 32'h2, 32'h33, 32'h0, 32'h0, 32'h0};
  int mk [8] = '{32'h1ff, 32'hf, 32'h3ff, 32'h3, 32'h3f, 32'h0, 32'h0, 32'h0};
  int cw [5] = '{32'h4, 32'h6, 32'h0, 32'h5, 32'h7};

  // short hold-off steps and loss window keep the run brief
  rifs_top #(.HO_STEP_00(4), .HO_STEP_01(4), .HO_STEP_10(4), .HO_STEP_11(4),
    .LOS_TIMEOUT(16)) rifs_top_inst (.CORE_CLK(clk), .RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .REF_EDGE(ref_edge), .VCXO_PULSE(vcxo),
    .PLL_UNLOCK(unlock), .REF_SELECT(ref_sel), .PLL_HOLDOVER(hold),
    .INPUT_POWERDOWN(pd), .INPUT_LOS(los), .LIVE_PLL1_UNLOCK(live),
    .STICKY_PLL1_UNLOCK(sticky), .LOCK(lock));
  rifs_ref_src rifs_ref_src_inst (.clk(clk), .run(run), .period(period),
    .edge_o(ref_edge));

  always #10 clk = ~clk;
  // random pulses: the hold-off count must follow them, not the clock
  always @(posedge clk) vcxo <= 1'($urandom % 2);
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer; zero wait states are never assumed
  task automatic bus(input logic [11:0] a, input logic w,
    input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input int i, input logic [31:0] d);
    bus(12'(i * 4), 1'b1, d);
    if (i < 4) m[i] = d & mk[i];
  endtask
  task automatic rc(input int i);
    bus(12'(i * 4), 1'b0, 32'h0);
    chk(rd, 32'(m[i] & mk[i]));
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wl(input int b, input logic v);
    for (int t = 0; t < 4000 && los[b] !== v; t++) @(negedge clk);
  endtask

  initial
  begin
    void'($urandom(32'hd3925872));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rc(i);
    repeat (12)
    begin
      n = $urandom % 4;
      wr(n, $urandom);
      rc(n);
    end
    wr(1, 32'hb);
    // every re-validation code, undivided and divided by four
    for (int k = 0; k < 8; k++)
    begin
      wr(0, 32'(k / 4) << 5);
      wr(3, 32'(k % 4));
      run <= 2'h2;
      tick(30);
      chk(los[0], 1'b1);
      @(posedge clk) run <= 2'h3;
      n = 0;
      for (int t = 0; t < 3000 && los[0] !== 1'b0; t++)
      begin
        @(negedge clk);
        n += ref_edge[0];
      end
      chk(32'(n), 32'((k % 4 == 0 ? 2 : 8 << (k % 4)) * (k / 4 ? 4 : 1)));
    end
    @(posedge clk) period <= 8'(2 + $urandom % 10);
    wl(1, 1'b0);
    // manual modes follow the choice, automatic ones ignore it
    for (int k = 0; k < 5; k++)
    begin
      wr(0, cw[k]);
      tick(3);
      chk(ref_sel, 1'(k < 2));
    end
    wr(0, 32'h1);
    run <= 2'h2;
    wl(0, 1'b1);
    tick(3);
    chk(ref_sel, 1'b1);
    @(posedge clk) run <= 2'h3;
    wl(0, 1'b0);
    tick(3);
    chk(ref_sel, 1'b1);
    wr(0, 32'h11);
    run <= 2'h2;
    wl(0, 1'b1);
    @(posedge clk) run <= 2'h3;
    wl(0, 1'b0);
    tick(3);
    chk(ref_sel, 1'b0);
    // hold-off of three steps of four pulses before the switch
    wr(2, 32'h3);
    wr(0, 32'h3);
    run <= 2'h2;
    wl(0, 1'b1);
    // the pulse on show now is the first one the counter takes; the
    // count runs on to the edge after the switch, so up to two extra
    n = vcxo;
    for (int t = 0; t < 3000 && ref_sel !== 1'b1; t++)
    begin
      @(negedge clk);
      n += vcxo;
    end
    chk(32'(n >= 12 && n <= 14), 32'h1);
    @(posedge clk) run <= 2'h3;
    wl(0, 1'b0);
    wr(0, 32'h2);
    run <= 2'h2;
    wl(0, 1'b1);
    tick(3);
    chk({ref_sel, hold, live, lock}, 4'b0110);
    wr(0, 32'h42);
    tick(3);
    chk({live, lock}, 2'b01);
    @(posedge clk) unlock <= 1'b1;
    tick(3);
    chk({live, lock}, 2'b10);
    @(posedge clk) unlock <= 1'b0;
    wr(4, 32'h20);
    bus(RIFS_OFS_STATUS, 1'b0, 32'h0);
    chk(rd[5], 1'b0);
    wr(0, 32'h142);
    tick(3);
    chk({pd, los[1]}, 3'b101);
    test_done();
  end
endmodule
`default_nettype wire
